// *** common/bfx_pkg.sv ***
// What this block does
// - field clear forces the selected run of destination bits to zero and keeps the rest.
// - field insert replaces the selected run with the same number of low source bits from bit 0 upward.
// - signed extract moves the field to the bottom and replicates its top bit up to bit 31.
// - unsigned extract moves the field to the bottom and fills the upper bits with zeros.
// - byte and halfword extension first rotate the source right by 0, 8, 16 or 24.
// - with no rotation field the source passes unrotated to extension.
// - byte extension takes bits 7 to 0 of the rotated value, signed or zero extended to 32 bits.
// - halfword extension takes bits 15 to 0 of the rotated value, signed or zero extended to 32 bits.
// - none of these operations changes the condition flags.
package bfx_pkg;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned POS_W = 5;
  localparam int unsigned WID_W = 6;
  localparam int unsigned ROT_W = 2;
  localparam int unsigned REG_IDX_W = 4;
  localparam int unsigned FLAG_W = 4;
  localparam logic [REG_IDX_W-1:0] STACK_PTR_IDX = 4'hd;
  localparam logic [REG_IDX_W-1:0] PROG_CNT_IDX = 4'hf;
  localparam logic [WORD_W-1:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [WORD_W-1:0] ONES_WORD = 32'hffff_ffff;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 4'h0;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned HALF_W = 16;

  typedef enum logic [3:0] {
    field_clear_op,
    field_insert_op,
    signed_field_extract_op,
    unsigned_field_extract_op,
    signed_byte_extend_op,
    signed_half_extend_op,
    unsigned_byte_extend_op,
    unsigned_half_extend_op
  } bfx_op_t;
endpackage

// *** hw/bfx_core.sv ***
`timescale 1ns/1ns
`default_nettype none
module bfx_core
  import bfx_pkg::*;
(
  // operation
  input wire bfx_op_t op,
  input wire logic [POS_W-1:0] field_lsb,
  input wire logic [WID_W-1:0] field_width,
  input wire logic rotate_present,
  input wire logic [ROT_W-1:0] rotate_right_amount,
  // operands
  input wire logic [WORD_W-1:0] dest_old,
  input wire logic [WORD_W-1:0] first_source_operand,
  input wire logic [WORD_W-1:0] second_source_operand,
  // result
  output logic [WORD_W-1:0] result
);
  // mask of width ones, saturating at a full word
  function automatic logic [WORD_W-1:0] low_mask(input logic [WID_W-1:0] w);
    logic [WORD_W:0] m;
    m = (33'h1_0000_0001 - 33'h1_0000_0000) << w;
    low_mask = m[WORD_W-1:0] - 32'h0000_0001;
    if (w >= WID_W'(WORD_W))
      low_mask = ONES_WORD;
  endfunction

  logic [WORD_W-1:0] fmask;
  logic [WORD_W-1:0] pmask;
  logic [WORD_W-1:0] fld;
  logic [WORD_W-1:0] rot;
  logic [WORD_W-1:0] sgn;
  logic [POS_W:0] top;
  logic [POS_W-1:0] rsh;

  // pure combinational datapath
  always_comb
  begin
    fmask = low_mask(field_width);
    pmask = fmask << field_lsb;
    fld = (first_source_operand >> field_lsb) & fmask;
    top = {1'b0, field_lsb} + field_width[POS_W:0] - 6'h01;
    sgn = {WORD_W{first_source_operand[top[POS_W-1:0]]}} & ~fmask;
    // absent rotation forced to zero
    rsh = rotate_present ? {rotate_right_amount, 3'h0} : 5'h00;
    rot = (second_source_operand >> rsh) |
          (second_source_operand << (6'h20 - {1'b0, rsh}));
    if (rsh == 5'h00)
      rot = second_source_operand;
    case (op)
      field_clear_op: result = dest_old & ~pmask;
      field_insert_op:
        result = (dest_old & ~pmask) |
                 ((first_source_operand << field_lsb) & pmask);
      signed_field_extract_op: result = fld | sgn;
      unsigned_field_extract_op: result = fld;
      signed_byte_extend_op:
        result = {{(WORD_W-BYTE_W){rot[BYTE_W-1]}}, rot[BYTE_W-1:0]};
      unsigned_byte_extend_op:
        result = {{(WORD_W-BYTE_W){1'b0}}, rot[BYTE_W-1:0]};
      signed_half_extend_op:
        result = {{(WORD_W-HALF_W){rot[HALF_W-1]}}, rot[HALF_W-1:0]};
      unsigned_half_extend_op:
        result = {{(WORD_W-HALF_W){1'b0}}, rot[HALF_W-1:0]};
      default: result = dest_old;
    endcase
  end
endmodule
`default_nettype wire

// *** hw/bfx_unit.sv ***
`timescale 1ns/1ns
`default_nettype none
module bfx_unit
  import bfx_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // issue
  input wire logic issue_valid,
  input wire logic cond_pass,
  input wire bfx_op_t op,
  input wire logic [POS_W-1:0] field_lsb,
  input wire logic [WID_W-1:0] field_width,
  input wire logic rotate_present,
  input wire logic [ROT_W-1:0] rotate_right_amount,
  input wire logic [REG_IDX_W-1:0] dest_idx,
  // operands from register file
  input wire logic [WORD_W-1:0] dest_old,
  input wire logic [WORD_W-1:0] first_source_operand,
  input wire logic [WORD_W-1:0] second_source_operand,
  // flags in
  input wire logic [FLAG_W-1:0] flags_in,
  // write back
  output logic wr_en,
  output logic [REG_IDX_W-1:0] wr_idx,
  output logic [WORD_W-1:0] wr_data,
  output logic [FLAG_W-1:0] flags_out
);
  logic [WORD_W-1:0] core_result;
  logic wr_en_reg, wr_en_next;
  logic [REG_IDX_W-1:0] wr_idx_reg, wr_idx_next;
  logic [WORD_W-1:0] wr_data_reg, wr_data_next;
  logic [FLAG_W-1:0] flags_reg, flags_next;

  bfx_core u_core (
    .op(op),
    .field_lsb(field_lsb),
    .field_width(field_width),
    .rotate_present(rotate_present),
    .rotate_right_amount(rotate_right_amount),
    .dest_old(dest_old),
    .first_source_operand(first_source_operand),
    .second_source_operand(second_source_operand),
    .result(core_result)
  );

  // next write-back; flags only pass through, never altered
  always_comb
  begin
    wr_en_next = issue_valid & cond_pass;
    wr_idx_next = dest_idx;
    wr_data_next = core_result;
    flags_next = flags_in;
    if (!(issue_valid & cond_pass))
    begin
      // keep data stable so a failed condition has no visible effect
      wr_idx_next = wr_idx_reg;
      wr_data_next = wr_data_reg;
    end
  end

  // registered write-back stage, one cycle latency
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      wr_en_reg <= 1'b0;
      wr_idx_reg <= '0;
      wr_data_reg <= ZERO_WORD;
      flags_reg <= FLAGS_RESET;
    end
    else
    begin
      wr_en_reg <= wr_en_next;
      wr_idx_reg <= wr_idx_next;
      wr_data_reg <= wr_data_next;
      flags_reg <= flags_next;
    end
  end

  assign wr_en = wr_en_reg;
  assign wr_idx = wr_idx_reg;
  assign wr_data = wr_data_reg;
  assign flags_out = flags_reg;

  a_cond_write_gate: assert property (@(posedge ref_clk) disable iff (srst)
    !(issue_valid && cond_pass) |=> !wr_en && $stable(wr_data))
    else $error("write not suppressed on failed condition");
  a_write_on_pass: assert property (@(posedge ref_clk) disable iff (srst)
    issue_valid && cond_pass |=> wr_en && wr_idx == $past(dest_idx))
    else $error("write missing on passed condition");
  a_flags_unchanged: assert property (@(posedge ref_clk) disable iff (srst)
    1'b1 |=> flags_out == $past(flags_in))
    else $error("flags changed by datapath op");
  a_clear_zeroes: assert property (@(posedge ref_clk) disable iff (srst)
    issue_valid && cond_pass && op == field_clear_op
    |=> ((wr_data >> $past(field_lsb)) & 32'h0000_0001) == ZERO_WORD)
    else $error("field clear left start bit set");
  a_unsigned_field_extract_op_low: assert property (@(posedge ref_clk) disable iff (srst)
    issue_valid && cond_pass && op == unsigned_field_extract_op &&
    field_width == 6'h01 |=> wr_data[WORD_W-1:1] == 31'h0000_0000 &&
    wr_data[0] == $past(first_source_operand[field_lsb]))
    else $error("unsigned extract wrong");
  a_signed_field_extract_op_sign: assert property (@(posedge ref_clk) disable iff (srst)
    issue_valid && cond_pass && op == signed_field_extract_op &&
    field_width == 6'h01 |=> wr_data == {WORD_W{
    $past(first_source_operand[field_lsb])}})
    else $error("signed extract not replicated");
  a_insert_low: assert property (@(posedge ref_clk) disable iff (srst)
    issue_valid && cond_pass && op == field_insert_op && field_lsb == 5'h00
    && field_width == 6'h01 |=> wr_data[0] ==
    $past(first_source_operand[0]) &&
    wr_data[WORD_W-1:1] == $past(dest_old[WORD_W-1:1]))
    else $error("insert wrong");
  a_byte_sext: assert property (@(posedge ref_clk) disable iff (srst)
    issue_valid && cond_pass && op == signed_byte_extend_op && !rotate_present
    |=> wr_data == {{24{$past(second_source_operand[7])}},
    $past(second_source_operand[7:0])})
    else $error("byte sign extend wrong");
  a_half_zext_rot: assert property (@(posedge ref_clk) disable iff (srst)
    issue_valid && cond_pass && op == unsigned_half_extend_op &&
    rotate_present && rotate_right_amount == 2'h2
    |=> wr_data == {16'h0000, $past(second_source_operand[31:16])})
    else $error("halfword rotate extend wrong");
endmodule
`default_nettype wire

// *** tb/bfx_rf_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module bfx_rf_model
  import bfx_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // write back
  input wire logic wr_en,
  input wire logic [REG_IDX_W-1:0] wr_idx,
  input wire logic [WORD_W-1:0] wr_data,
  // destination read
  input wire logic [REG_IDX_W-1:0] rd_idx,
  output logic [WORD_W-1:0] rd_data
);
  logic [WORD_W-1:0] rf_reg [16];
  // nonzero seed so a clear is visible
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      rf_reg <= '{default: 32'hc3a5_96f0};
    else if (wr_en)
      rf_reg[wr_idx] <= wr_data;
  end
  assign rd_data = rf_reg[rd_idx];
endmodule
`default_nettype wire

// *** tb/bfx_unit_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module bfx_unit_tb;
  import bfx_pkg::*;
  logic ref_clk = 0, srst = 1, issue_valid = 0, cond_pass = 0, rp = 0;
  bfx_op_t op = field_clear_op;
  logic [4:0] lsb = 0;
  logic [5:0] wid = 1;
  logic [1:0] rot = 0;
  logic [3:0] fl = 0, flo, wr_idx;
  logic [31:0] s = 0, d = 32'hc3a5_96f0, dold, wd;
  logic wr_en;
  int fails = 0, checked = 0;
  always #4 ref_clk = ~ref_clk;
  bfx_rf_model u_bfx_rf_model (.ref_clk(ref_clk), .srst(srst),
    .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wd), .rd_idx(4'h2),
    .rd_data(dold));
  // destination 2: never the stack pointer or program counter
  bfx_unit u_bfx_unit (.ref_clk(ref_clk), .srst(srst),
    .issue_valid(issue_valid), .cond_pass(cond_pass), .op(op),
    .field_lsb(lsb), .field_width(wid), .rotate_present(rp),
    .rotate_right_amount(rot), .dest_idx(4'h2), .dest_old(dold),
    .first_source_operand(s), .second_source_operand(s),
    .flags_in(fl), .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wd),
    .flags_out(flo));
  task automatic chk(string n, logic [31:0] g, logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // one issue; the model write lands before the next issue
  task automatic run(bfx_op_t o, logic c, logic [31:0] e);
    op = o;
    cond_pass = c;
    fl = fl + 4'h1;
    issue_valid = 1;
    @(posedge ref_clk);
    #1 issue_valid = 0;
    chk("wr_en", {31'h0, wr_en}, {31'h0, c});
    chk("wr_data", wd, c ? e : d);
    chk("flags", {28'h0, flo}, {28'h0, fl});
    chk("wr_idx", {28'h0, wr_idx}, 32'h0000_0002);
    if (c)
      d = e;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic t_field(logic [4:0] l, logic [5:0] w);
    logic [63:0] m, f;
    m = (64'h1 << w) - 64'h1;
    lsb = l;
    wid = w;
    f = ({32'h0, s} >> l) & m;
    run(field_clear_op, 1, d & ~32'(m << l));
    run(field_insert_op, 1, (d & ~32'(m << l)) | 32'(({32'h0, s} & m) << l));
    f = ({32'h0, s} >> l) & m;
    run(unsigned_field_extract_op, 1, 32'(f));
    run(signed_field_extract_op, 1, 32'(s[l+w-1] ? f | ~m : f));
  endtask
  task automatic t_ext(logic p, logic [1:0] r);
    logic [31:0] v;
    rp = p;
    rot = r;
    v = p ? 32'({s, s} >> (8 * r)) : s;
    run(signed_byte_extend_op, 1, {{24{v[7]}}, v[7:0]});
    run(unsigned_byte_extend_op, 1, {24'h0, v[7:0]});
    run(signed_half_extend_op, 1, {{16{v[15]}}, v[15:0]});
    run(unsigned_half_extend_op, 1, {16'h0, v[15:0]});
  endtask
  task automatic t_cond();
    lsb = 5'h4;
    wid = 6'h8;
    run(field_clear_op, 0, 32'h0);
    run(signed_byte_extend_op, 0, 32'h0);
  endtask
  task automatic stop_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #(8 * 3000);
    fails++;
    stop_test();
  end
  initial
  begin
    repeat (6) @(posedge ref_clk);
    #1 srst = 0;
    chk("rst", wd, 32'h0);
    s = 32'h8f3c_e1a7;
    for (int k = 0; k < 2; k++)
    begin
      t_field(5'h0, 6'h20);
      t_field(5'h8, 6'hc);
      t_field(5'h1f, 6'h1);
      t_field(5'h14, 6'h4);
      t_field(5'h0, 6'h1);
      for (int r = 0; r < 4; r++)
        t_ext(1, 2'(r));
      t_ext(0, 2'h3);
      s = ~s;
    end
    t_cond();
    stop_test();
  end
endmodule
`default_nettype wire
